// ### hw/period_timer_sysclk_pwm.sv
`timescale 1ns/10ps
`default_nettype none
module period_timer_sysclk_pwm #(
    parameter logic [1:0] ROLE_STANDALONE = pwm_pkg::ROLE_STANDALONE,
    parameter logic [1:0] ROLE_MASTER     = pwm_pkg::ROLE_MASTER,
    parameter logic [1:0] ROLE_SLAVE      = pwm_pkg::ROLE_SLAVE
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        sleep,
    input  wire logic        sync_clock_in,
    output logic             sync_clock_out,
    output logic             sync_clock_oe,
    output logic             clock_out_pin,
    input  wire logic        driver_request,
    output logic             driver_duty,
    output logic             irq
);
    // Software-visible register state; every writable register lives in lane 0 of the bus
    // and unimplemented bits are never stored, so they read back as zero
    logic [2:0]  control;
    logic [7:0]  period_value;
    logic [7:0]  tick_count;
    logic [7:0]  duty_buffer;
    logic [7:0]  duty_active;
    logic [7:0]  phase_buffer;
    logic [7:0]  phase_active;
    logic [1:0]  sync_role_select;
    logic [1:0]  status;
    logic [1:0]  mask;
    // Time base: the prescaler divides clk down to one tick, and each tick
    // advances the period count; a match with period_value ends the period
    logic [3:0]  prescale_count;
    logic [3:0]  prescale_limit;
    logic        tick;
    logic        match;
    logic        wrap;
    // Sync pin path: two flops for the asynchronous pin, one more for edge detect
    logic        sync_meta;
    logic        sync_sync;
    logic        sync_prev;
    logic        sync_rise;
    logic        reload;
    logic        is_master;
    logic        is_slave;
    logic        pwm_raw;
    // Slave phase shift: counts ticks after the master edge, then times the window
    logic [7:0]  phase_count;
    logic        phase_wait;
    logic        slave_clk;
    // Bus side: reads take one wait cycle so read data can come from flops
    logic        read_done;
    logic        wr_en;

    // Write strobe decode for one register offset, shared by every writer
    function automatic logic wr_hit(input logic       we,
                                    input logic [5:0] addr,
                                    input logic [5:0] target);
        return we && (addr == target);
    endfunction : wr_hit

    // Only byte lane 0 carries register bits; other lanes alone write nothing
    assign wr_en       = write && byteenable[0];
    // Writes never stall; a read stalls exactly one cycle while data is fetched
    assign waitrequest = read && !read_done;
    // Role decode; code 3 is left to behave as stand-alone
    assign is_master   = (sync_role_select == ROLE_MASTER);
    assign is_slave    = (sync_role_select == ROLE_SLAVE);

    // Prescale limit per select code
    // Limit is the divide ratio minus one, so the count wraps on the tick
    // A wider divide only stretches the tick; the period count stays 8 bits
    always_comb begin
        unique case (control[1:0])
            2'h0: prescale_limit = pwm_pkg::PRESCALE_LIMIT_DIV1;
            2'h1: prescale_limit = pwm_pkg::PRESCALE_LIMIT_DIV4;
            2'h2: prescale_limit = pwm_pkg::PRESCALE_LIMIT_DIV8;
            2'h3: prescale_limit = pwm_pkg::PRESCALE_LIMIT_DIV16;
        endcase
    end

    // Tick fires while running and awake
    // Sleep gates the tick here and in the prescaler so both freeze together
    assign tick  = control[pwm_pkg::RUN_BIT] && !sleep
                   && (prescale_count == prescale_limit);
    assign match = (tick_count == period_value);
    assign wrap  = tick && match;
    assign sync_rise = sync_sync && !sync_prev;
    // Slave reloads on its own wrap or the master edge
    // Both sources are ORed, so whichever comes first refreshes the buffers
    assign reload = wrap || (is_slave && sync_rise && !sleep);

    // Sync pin synchroniser; the first stage is read only by the second
    // Two stages trade one cycle of latency for a settled level
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_meta <= 1'b0;
            sync_sync <= 1'b0;
        end else begin
            sync_meta <= sync_clock_in;
            sync_sync <= sync_meta;
        end
    end

    // Edge detect flop; resets low like the idle pin, so no false edge
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_prev <= 1'b0;
        end else begin
            sync_prev <= sync_sync;
        end
    end

    // Prescaler; cleared by writes to count or control
    // Clearing it makes the first tick after a write a full divide period
    always_ff @(posedge clk) begin
        if (srst) begin
            prescale_count <= 4'h0;
        end else if (wr_hit(wr_en, address, pwm_pkg::ADDR_COUNT)
                     || wr_hit(wr_en, address, pwm_pkg::ADDR_CONTROL)) begin
            prescale_count <= 4'h0;
        end else if (control[pwm_pkg::RUN_BIT] && !sleep) begin
            prescale_count <= (prescale_count == prescale_limit) ? 4'h0
                              : prescale_count + 4'h1;
        end
    end

    // Timer count; software write wins over counting
    // A control write leaves the count alone; only the prescaler restarts
    always_ff @(posedge clk) begin
        if (srst) begin
            tick_count <= pwm_pkg::COUNT_RESET;
        end else if (wr_hit(wr_en, address, pwm_pkg::ADDR_COUNT)) begin
            tick_count <= writedata[7:0];
        end else if (wrap) begin
            tick_count <= pwm_pkg::COUNT_RESET;
        end else if (tick) begin
            tick_count <= tick_count + 8'h01;
        end
    end

    // Timer control: run bit and prescale select only
    // Bits 7-3 are not stored, so writes to them vanish and reads give zero
    always_ff @(posedge clk) begin
        if (srst) begin
            control <= pwm_pkg::CONTROL_RESET;
        end else if (wr_hit(wr_en, address, pwm_pkg::ADDR_CONTROL)) begin
            control <= writedata[2:0] & pwm_pkg::CONTROL_MASK;
        end
    end

    // Period value; compared every cycle, so a write lands at once
    // Writing it below the current count makes the timer run on to wrap
    always_ff @(posedge clk) begin
        if (srst) begin
            period_value <= pwm_pkg::PERIOD_RESET;
        end else if (wr_hit(wr_en, address, pwm_pkg::ADDR_PERIOD)) begin
            period_value <= writedata[7:0];
        end
    end

    // Duty buffer; software may rewrite it at any time
    // The running period keeps its own copy, so a new value never cuts a pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            duty_buffer <= pwm_pkg::BUFFER_RESET;
        end else if (wr_hit(wr_en, address, pwm_pkg::ADDR_DUTY)) begin
            duty_buffer <= writedata[7:0];
        end
    end

    // Phase buffer; copied to the active side at every reload, in any role
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_buffer <= pwm_pkg::BUFFER_RESET;
        end else if (wr_hit(wr_en, address, pwm_pkg::ADDR_PHASE)) begin
            phase_buffer <= writedata[7:0];
        end
    end

    // Role select sits in the top two bits of the mode register
    // The rest of that register is not stored here and reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_role_select <= ROLE_STANDALONE;
        end else if (wr_hit(wr_en, address, pwm_pkg::ADDR_MODE)) begin
            sync_role_select <= writedata[pwm_pkg::ROLE_LSB +: 2];
        end
    end

    // Interrupt mask, same layout as the status register
    always_ff @(posedge clk) begin
        if (srst) begin
            mask <= 2'h0;
        end else if (wr_hit(wr_en, address, pwm_pkg::ADDR_MASK)) begin
            mask <= writedata[pwm_pkg::STAT_W-1:0];
        end
    end

    // Active duty changes only at a reload point, never mid-period
    always_ff @(posedge clk) begin
        if (srst) begin
            duty_active <= pwm_pkg::BUFFER_RESET;
        end else if (reload) begin
            duty_active <= duty_buffer;
        end
    end

    // Active phase follows the same reload points
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_active <= pwm_pkg::BUFFER_RESET;
        end else if (reload) begin
            phase_active <= phase_buffer;
        end
    end

    // Raw PWM: high while count below active duty
    // Duty above the period value gives a clock that never falls
    // Duty zero gives a clock that never rises, which parks the driver except in a slave with nonzero phase
    assign pwm_raw = (tick_count < duty_active);

    // Slave phase delay counted in prescaled ticks after master edge
    // A master edge restarts the delay; zero phase opens the window at once
    // Limitation: with nonzero phase, a master edge inside the window cuts the window short
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_count <= 8'h00;
            phase_wait  <= 1'b0;
            slave_clk   <= 1'b0;
        end else if (is_slave && sync_rise && !sleep) begin
            phase_count <= phase_buffer;
            phase_wait  <= (phase_buffer != 8'h00);
            slave_clk   <= (phase_buffer == 8'h00) && (duty_buffer != 8'h00);
        end else if (phase_wait && tick) begin
            // Window opens on the last delay tick
            phase_count <= phase_count - 8'h01;
            if (phase_count == 8'h01) begin
                phase_wait <= 1'b0;
                slave_clk  <= 1'b1;
            end
        end else if (!phase_wait && tick) begin
            // Shifted high window lasts duty ticks, or one tick after a delay with duty zero
            slave_clk <= slave_clk && (phase_count + 8'h01 < duty_active);
            phase_count <= phase_count + 8'h01;
        end
    end

    // System clock pin; registered so it never glitches, holds level in sleep
    always_ff @(posedge clk) begin
        if (srst) begin
            clock_out_pin <= 1'b0;
        end else if (!sleep) begin
            clock_out_pin <= is_slave ? slave_clk : pwm_raw;
        end
    end

    // Sync pin data follows the unshifted PWM through one flop, like the
    // clock pin, so a master's two pins change on the same edge
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_clock_out <= 1'b0;
        end else if (!sleep) begin
            sync_clock_out <= pwm_raw;
        end
    end

    // Sync pin is driven only by a master; others leave it to the far side
    // Switching role mid-run turns the driver on or off at the next edge
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_clock_oe <= 1'b0;
        end else if (!sleep) begin
            sync_clock_oe <= is_master;
        end
    end

    // Driver on-time can never exceed the clock high time
    // The analog loop asks for on-time; the clock high window caps it
    assign driver_duty = driver_request && clock_out_pin;

    // Sticky status; hardware set wins over write-one-clear
    // A clear on the same edge as a new event loses, so no event is lost
    always_ff @(posedge clk) begin
        if (srst) begin
            status <= 2'h0;
        end else begin
            status[pwm_pkg::STAT_MATCH] <= wrap ||
                (status[pwm_pkg::STAT_MATCH]
                 && !(wr_hit(wr_en, address, pwm_pkg::ADDR_STATUS)
                      && writedata[pwm_pkg::STAT_MATCH]));
            // Sync edge flag only means something in the slave role
            status[pwm_pkg::STAT_SYNC] <= (is_slave && sync_rise) ||
                (status[pwm_pkg::STAT_SYNC]
                 && !(wr_hit(wr_en, address, pwm_pkg::ADDR_STATUS)
                      && writedata[pwm_pkg::STAT_SYNC]));
        end
    end

    // Level interrupt: high while any unmasked status bit stays set
    assign irq = |(status & mask);

    // Read path: one wait cycle, data registered
    // read_done drops the stall for one cycle, then rearms for the next read
    // Unmapped offsets read zero so software can probe safely
    always_ff @(posedge clk) begin
        if (srst) begin
            readdata  <= 32'h0;
            read_done <= 1'b0;
        end else begin
            read_done <= read && !read_done;
            if (read && !read_done) begin
                unique case (address)
                    pwm_pkg::ADDR_CONTROL: readdata <= {29'h0, control};
                    pwm_pkg::ADDR_PERIOD:  readdata <= {24'h0, period_value};
                    pwm_pkg::ADDR_COUNT:   readdata <= {24'h0, tick_count};
                    pwm_pkg::ADDR_DUTY:    readdata <= {24'h0, duty_buffer};
                    pwm_pkg::ADDR_PHASE:   readdata <= {24'h0, phase_buffer};
                    pwm_pkg::ADDR_MODE:    readdata <= {24'h0, sync_role_select, 6'h0};
                    pwm_pkg::ADDR_STATUS:  readdata <= {30'h0, status};
                    pwm_pkg::ADDR_MASK:    readdata <= {30'h0, mask};
                    pwm_pkg::ADDR_ACTIVE:  readdata <= {16'h0, phase_active, duty_active};
                    default:               readdata <= 32'h0;
                endcase
            end
        end
    end
endmodule : period_timer_sysclk_pwm
`default_nettype wire

// ### hw/pwm_pkg.sv
// Contract
// - Timer counts only while timer_run is set
// - Prescale codes 00..11 divide by 1,4,8,16
// - Control bits 7-3 read zero, ignore writes
// - Stand-alone: PWM is system clock, fixed duty
// - Clock duty bounds power driver on-time
// - Master drives system clock on sync pin
// - Slave ORs sync clock with match, reloads buffers
// - Slave delays clock start by phase counts
// - Period is period_value plus one ticks
// - Match then next tick clears count, loads duty
// - Output high for duty counts, then low
// - Duty writes take effect only after match
// - Sleep freezes timer, state and clock pin; in slave role STAT_SYNC still sets on master edges
// - Reset sets tick_count 00h, period_value FFh
// - Prescaler cleared on count/control write, reset
// - Each match sets period_match_flag
package pwm_pkg;
    localparam logic [5:0] ADDR_CONTROL  = 6'h00;
    localparam logic [5:0] ADDR_PERIOD   = 6'h04;
    localparam logic [5:0] ADDR_COUNT    = 6'h08;
    localparam logic [5:0] ADDR_DUTY     = 6'h0c;
    localparam logic [5:0] ADDR_PHASE    = 6'h10;
    localparam logic [5:0] ADDR_MODE     = 6'h14;
    localparam logic [5:0] ADDR_STATUS   = 6'h18;
    localparam logic [5:0] ADDR_MASK     = 6'h1c;
    localparam logic [5:0] ADDR_ACTIVE   = 6'h20;
    localparam int         RUN_BIT       = 2;
    localparam int         ROLE_LSB      = 6;
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam logic [7:0] PERIOD_RESET  = 8'hff;
    localparam logic [2:0] CONTROL_MASK  = 3'h7;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic [7:0] BUFFER_RESET  = 8'h00;
    localparam logic [3:0] PRESCALE_LIMIT_DIV1  = 4'h0;
    localparam logic [3:0] PRESCALE_LIMIT_DIV4  = 4'h3;
    localparam logic [3:0] PRESCALE_LIMIT_DIV8  = 4'h7;
    localparam logic [3:0] PRESCALE_LIMIT_DIV16 = 4'hf;
    localparam logic [1:0] ROLE_STANDALONE = 2'h0;
    localparam logic [1:0] ROLE_MASTER     = 2'h1;
    localparam logic [1:0] ROLE_SLAVE      = 2'h2;
    localparam int         STAT_MATCH    = 0;
    localparam int         STAT_SYNC     = 1;
    localparam int         STAT_W        = 2;
endpackage : pwm_pkg

// ### tb/period_timer_sysclk_pwm_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module period_timer_sysclk_pwm_tb_top;
    logic        clk, srst, read, write, sleep, drv_req, sync_en, sync_clk, wait_req;
    logic        oe, sco, pin, drv, irq;
    logic [5:0]  address;
    logic [31:0] writedata, readdata, rv;
    int          num_errors, samples_checked;
    always #5 clk = ~clk;
    period_timer_sysclk_pwm dut (.clk(clk), .srst(srst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(wait_req), .sleep(sleep), .sync_clock_in(sync_clk),
        .sync_clock_out(sco), .sync_clock_oe(oe), .clock_out_pin(pin),
        .driver_request(drv_req), .driver_duty(drv), .irq(irq));
    sync_master_model partner (.clk(clk), .enable(sync_en), .sync_clock(sync_clk));
    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : expect_eq
    // One bus cycle; read data lands in rv at the edge waitrequest is low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        @(posedge clk);
        while (wait_req !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (wait_req !== 1'b0) begin
            num_errors++;
            $display("MISMATCH t=%0t bus answer timed out", $time);
        end
        rv = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic t_reset_regs();
        bus(0, pwm_pkg::ADDR_COUNT, 0);
        expect_eq(rv, 32'h00);
        bus(0, pwm_pkg::ADDR_PERIOD, 0);
        expect_eq(rv, 32'hff);
        bus(1, 6'h3c, 32'h5a);
        bus(0, 6'h3c, 0);
        expect_eq(rv, 32'h0);
    endtask : t_reset_regs
    // High time and rise position over two periods for every prescale code
    task automatic t_period_duty();
        int hi, at, div;
        logic last;
        bus(1, pwm_pkg::ADDR_PERIOD, 32'h5);
        bus(1, pwm_pkg::ADDR_DUTY, 32'h2);
        for (int c = 0; c < 4; c++) begin
            div = (c == 0) ? 1 : 4 << (c - 1);
            bus(1, pwm_pkg::ADDR_CONTROL, 32'h4 | c);
            @(posedge pin);
            @(posedge pin);
            hi = 0;
            at = 0;
            last = 1'b1;
            for (int k = 1; k <= 12 * div; k++) begin
                @(posedge clk);
                hi += int'(pin === 1'b1);
                if (pin === 1'b1 && !last) at = k;
                last = pin;
            end
            expect_eq(32'(hi), 32'(4 * div));
            expect_eq(32'(at), 32'(6 * div + 1));
        end
    endtask : t_period_duty
    task automatic t_duty_defer();
        bus(1, pwm_pkg::ADDR_CONTROL, 32'h4);
        bus(1, pwm_pkg::ADDR_COUNT, 32'h0);
        bus(1, pwm_pkg::ADDR_DUTY, 32'h3);
        bus(0, pwm_pkg::ADDR_ACTIVE, 0);
        expect_eq(rv & 32'hff, 32'h2);
        repeat (8) @(posedge clk);
        bus(0, pwm_pkg::ADDR_ACTIVE, 0);
        expect_eq(rv & 32'hff, 32'h3);
    endtask : t_duty_defer
    task automatic t_stop_sleep();
        logic [31:0] a;
        bus(1, pwm_pkg::ADDR_CONTROL, 32'h3);
        bus(0, pwm_pkg::ADDR_COUNT, 0);
        a = rv;
        repeat (20) @(posedge clk);
        bus(0, pwm_pkg::ADDR_COUNT, 0);
        expect_eq(rv, a);
        bus(1, pwm_pkg::ADDR_CONTROL, 32'hff);
        bus(0, pwm_pkg::ADDR_CONTROL, 0);
        expect_eq(rv, 32'h7);
        sleep <= 1'b1;
        bus(0, pwm_pkg::ADDR_COUNT, 0);
        a = rv;
        repeat (40) @(posedge clk);
        bus(0, pwm_pkg::ADDR_COUNT, 0);
        expect_eq(rv, a);
        sleep <= 1'b0;
        repeat (40) @(posedge clk);
        bus(0, pwm_pkg::ADDR_COUNT, 0);
        expect_eq(32'(rv !== a), 32'h1);
    endtask : t_stop_sleep
    // Count is parked at zero before clearing so a held match cannot re-set the flag
    task automatic t_irq();
        bus(1, pwm_pkg::ADDR_MASK, 32'h1);
        bus(1, pwm_pkg::ADDR_CONTROL, 32'h4);
        repeat (10) @(posedge clk);
        expect_eq(32'(irq), 32'h1);
        bus(1, pwm_pkg::ADDR_CONTROL, 32'h0);
        bus(1, pwm_pkg::ADDR_COUNT, 32'h0);
        bus(1, pwm_pkg::ADDR_STATUS, 32'h1);
        @(posedge clk);
        expect_eq(32'(irq), 32'h0);
        bus(1, pwm_pkg::ADDR_MASK, 32'h0);
        bus(1, pwm_pkg::ADDR_CONTROL, 32'h4);
        repeat (10) @(posedge clk);
        expect_eq(32'(irq), 32'h0);
        bus(0, pwm_pkg::ADDR_STATUS, 0);
        expect_eq(rv & 32'h1, 32'h1);
    endtask : t_irq
    task automatic t_roles();
        int n;
        bus(1, pwm_pkg::ADDR_MODE, 32'({pwm_pkg::ROLE_MASTER, 6'h00}));
        repeat (2) @(posedge clk);
        expect_eq(32'(oe), 32'h1);
        bus(1, pwm_pkg::ADDR_PERIOD, 32'hff);
        bus(1, pwm_pkg::ADDR_PHASE, 32'h8);
        bus(1, pwm_pkg::ADDR_DUTY, 32'h4);
        bus(1, pwm_pkg::ADDR_MODE, 32'({pwm_pkg::ROLE_SLAVE, 6'h00}));
        bus(1, pwm_pkg::ADDR_COUNT, 32'h0);
        repeat (2) @(posedge clk);
        expect_eq(32'(oe), 32'h0);
        sync_en <= 1'b1;
        @(posedge sync_clk);
        n = 0;
        while (pin !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        expect_eq(32'(n >= 9 && n <= 16), 32'h1);
        bus(0, pwm_pkg::ADDR_ACTIVE, 0);
        expect_eq(rv & 32'hffff, 32'h0804);
        sync_en <= 1'b0;
    endtask : t_roles
    // Master: sync pin mirrors the clock pin, driver gated by the clock
    task automatic t_master_drive();
        bus(1, pwm_pkg::ADDR_MODE, 32'({pwm_pkg::ROLE_MASTER, 6'h00}));
        bus(1, pwm_pkg::ADDR_DUTY, 32'h2);
        bus(1, pwm_pkg::ADDR_PERIOD, 32'h5);
        bus(1, pwm_pkg::ADDR_COUNT, 32'h0);
        @(posedge pin);
        @(posedge pin);
        @(posedge clk);
        expect_eq(32'({pin, sco, drv}), 32'h7);
        drv_req <= 1'b0;
        @(posedge clk);
        expect_eq(32'({pin, drv}), 32'h2);
        drv_req <= 1'b1;
        @(negedge pin);
        @(posedge clk);
        expect_eq(32'({pin, sco, drv}), 32'h0);
    endtask : t_master_drive
    // Count write restarts the prescaler, so the next tick is 16 clocks away
    task automatic t_prescale_clear();
        bus(1, pwm_pkg::ADDR_PERIOD, 32'hff);
        bus(1, pwm_pkg::ADDR_CONTROL, 32'h7);
        bus(1, pwm_pkg::ADDR_COUNT, 32'h10);
        repeat (13) @(posedge clk);
        bus(0, pwm_pkg::ADDR_COUNT, 0);
        expect_eq(rv, 32'h10);
        bus(0, pwm_pkg::ADDR_COUNT, 0);
        expect_eq(rv, 32'h11);
        bus(1, pwm_pkg::ADDR_CONTROL, 32'h3);
        bus(0, pwm_pkg::ADDR_COUNT, 0);
        expect_eq(rv, 32'h11);
    endtask : t_prescale_clear
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        {clk, read, write, sleep, sync_en} = '0;
        {srst, drv_req} = 2'h3;
        {address, writedata, num_errors, samples_checked} = '0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset_regs();
        t_period_duty();
        t_duty_defer();
        t_stop_sleep();
        t_irq();
        t_roles();
        t_master_drive();
        t_prescale_clear();
        conclude();
    end
    // Whole sequence needs well under ten thousand cycles
    initial begin
        #500us;
        num_errors++;
        conclude();
    end
endmodule : period_timer_sysclk_pwm_tb_top
`default_nettype wire

// ### tb/pwm_sysclk_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_sysclk_chk (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        sleep,
    input wire logic        sync_clock_out,
    input wire logic        sync_clock_oe,
    input wire logic        clock_out_pin,
    input wire logic        driver_request,
    input wire logic        driver_duty,
    input wire logic        irq
);
    // All checks share the one clock and its reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_write_nowait: assert property (write |-> !waitrequest)
        else $error("write was stalled");
    chk_read_stall: assert property ($rose(read) |-> waitrequest)
        else $error("read answered without wait");
    chk_read_answer: assert property (read && waitrequest |=> !waitrequest)
        else $error("read answer late");
    chk_readdata_hold: assert property (!$past(read) && !$past(srst) |-> $stable(readdata))
        else $error("read data moved without read");
    chk_driver_bound: assert property (driver_duty == (clock_out_pin && driver_request))
        else $error("driver on outside clock high time");
    chk_master_mirror: assert property (sync_clock_oe |-> sync_clock_out == clock_out_pin)
        else $error("sync pin differs from system clock");
    chk_sleep_freeze: assert property ($past(sleep) && !$past(srst) |->
        $stable(clock_out_pin) && $stable(sync_clock_out))
        else $error("outputs moved in sleep");
    chk_reset_quiet: assert property ($past(srst) |-> !clock_out_pin && !irq && !sync_clock_oe)
        else $error("outputs active after reset");
endmodule : pwm_sysclk_chk
bind period_timer_sysclk_pwm pwm_sysclk_chk u_chk (.clk(clk), .srst(srst), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest), .sleep(sleep),
    .sync_clock_out(sync_clock_out), .sync_clock_oe(sync_clock_oe),
    .clock_out_pin(clock_out_pin), .driver_request(driver_request),
    .driver_duty(driver_duty), .irq(irq));
`default_nettype wire

// ### tb/sync_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module sync_master_model #(
    parameter int HALF = 100
) (
    input  wire logic clk,
    input  wire logic enable,
    output var logic  sync_clock
);
    int n;
    // Master clock square wave; held low while idle so no stray edge reaches the slave
    always_ff @(posedge clk) begin
        if (!enable) begin
            n <= 0;
            sync_clock <= 1'b0;
        end else begin
            n <= (n == HALF - 1) ? 0 : n + 1;
            if (n == 0) sync_clock <= ~sync_clock;
        end
    end
endmodule : sync_master_model
`default_nettype wire
